// *** core/aep_endpoint.sv ***
// memory-mapped slave endpoint with internal memory and a small control port
// assumes master logic on the same clock; reset comes synchronised from the system
`timescale 1ns/1ps
`include "aep_regs.svh"

module aep_endpoint
  import aep_pkg::*;
#(
  parameter int DATA_W     = 32,
  parameter bit LITE       = 1'b0,
  parameter logic [1:0] ACCESS = `AEP_MODE_RW,
  parameter bit USE_REGION = 1'b1,
  parameter int IDX_W      = 8
)(
  // clock and reset
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_srst,
  // write address channel
  input  wire aep_addr_s            i_aw,
  input  wire logic                 i_aw_valid,
  output logic                      o_aw_ready,
  // write data channel
  input  wire logic [DATA_W-1:0]    i_w_data,
  input  wire logic [DATA_W/8-1:0]  i_w_strb,
  input  wire logic                 i_w_last,
  input  wire logic                 i_w_user,
  input  wire logic                 i_w_valid,
  output logic                      o_w_ready,
  // write response channel
  output logic [3:0]                o_b_id,
  output logic [1:0]                o_b_resp,
  output logic                      o_b_user,
  output logic                      o_b_valid,
  input  wire logic                 i_b_ready,
  // read address channel
  input  wire aep_addr_s            i_ar,
  input  wire logic                 i_ar_valid,
  output logic                      o_ar_ready,
  // read data channel
  output logic [3:0]                o_r_id,
  output logic [DATA_W-1:0]         o_r_data,
  output logic [1:0]                o_r_resp,
  output logic                      o_r_last,
  output logic                      o_r_user,
  output logic                      o_r_valid,
  input  wire logic                 i_r_ready,
  // control port
  input  wire logic [7:0]           i_reg_addr,
  input  wire logic [31:0]          i_reg_wdata,
  input  wire logic                 i_reg_wr,
  input  wire logic                 i_reg_rd,
  output logic [31:0]               o_reg_rdata
);

  // build-time shape
  localparam int  LANE_W   = $clog2(DATA_W/8);
  localparam int  WORDS    = 2**IDX_W;
  localparam bit  HAS_WR   = (ACCESS != `AEP_MODE_RO);
  localparam bit  HAS_RD   = (ACCESS != `AEP_MODE_WO);
  localparam bit  WIDTH_OK = (DATA_W == 32) || (DATA_W == 64) || (DATA_W == 128) ||
                             (DATA_W == 256) || (DATA_W == 512) || (DATA_W == 1024);
  localparam bit  LITE_OK  = !LITE || (DATA_W == 32);

  // storage
  logic [DATA_W-1:0] mem [WORDS];

  // next beat address; fixed bursts step like incrementing ones, wrap stays in its window
  function automatic logic [31:0] aep_step(input logic [31:0] addr,
                                           input logic [2:0]  size,
                                           input logic [7:0]  len,
                                           input logic [1:0]  burst);
    logic [31:0] incr;
    logic [31:0] mask;
    incr = addr + (32'h1 << size);
    mask = (({24'h0, len} + 32'h1) << size) - 32'h1;
    if (burst == `AEP_BURST_WRAP)
      aep_step = (addr & ~mask) | (incr & mask);
    else
      aep_step = incr;
  endfunction : aep_step

  // word index; region bits may choose the upper half instead of address decode
  function automatic logic [IDX_W-1:0] aep_index(input logic [31:0] addr,
                                                 input logic [3:0]  region);
    if (USE_REGION)
      aep_index = {region[0], addr[LANE_W +: IDX_W-1]};
    else
      aep_index = addr[LANE_W +: IDX_W];
  endfunction : aep_index

  // control register and counters
  logic        ctrl_en;
  logic [15:0] wr_bursts;
  logic [15:0] rd_bursts;

  // write side state
  aep_wst_e    w_state;
  logic [31:0] wr_addr;
  logic [7:0]  wr_len;
  logic [7:0]  wr_cnt;
  logic [2:0]  wr_size;
  logic [1:0]  wr_burst;
  logic [3:0]  wr_region;

  // read side state
  aep_rst_e    r_state;
  logic [31:0] rd_addr;
  logic [7:0]  rd_len;
  logic [8:0]  rd_cnt;
  logic [2:0]  rd_size;
  logic [1:0]  rd_burst;
  logic [3:0]  rd_region;
  logic        rd_pending;

  // channel handshakes; qos, lock, cache, prot and user bits are never looked at
  wire aw_take = i_aw_valid && o_aw_ready;
  wire w_take  = i_w_valid  && o_w_ready;
  wire b_take  = o_b_valid  && i_b_ready;
  wire ar_take = i_ar_valid && o_ar_ready;
  wire r_take  = o_r_valid  && i_r_ready;

  // ready and valid decode, constant low for a removed direction and held low in reset
  assign o_aw_ready = HAS_WR && ctrl_en && !i_srst && (w_state == AEP_W_IDLE);
  assign o_w_ready  = HAS_WR && ctrl_en && !i_srst && (w_state == AEP_W_DATA);
  assign o_b_valid  = HAS_WR && !i_srst && (w_state == AEP_W_RESP);
  assign o_ar_ready = HAS_RD && ctrl_en && !i_srst && (r_state == AEP_R_IDLE);

  // responses are always okay, exclusive ones included
  assign o_b_resp = `AEP_RESP_OKAY;
  assign o_r_resp = `AEP_RESP_OKAY;
  assign o_b_user = 1'b0;
  assign o_r_user = 1'b0;

  // lite mode takes every request as a single beat
  wire [7:0] aw_len = LITE ? 8'h00 : i_aw.len;
  wire [7:0] ar_len = LITE ? 8'h00 : i_ar.len;

  // write beat: merge strobed lanes into the stored word
  wire [IDX_W-1:0]  wr_idx = aep_index(wr_addr, wr_region);
  wire [DATA_W-1:0] wr_old = mem[wr_idx];
  wire [DATA_W-1:0] wr_new;
  wire              wr_end = i_w_last || (wr_cnt == wr_len);

  genvar lane;
  generate
    for (lane = 0; lane < DATA_W/8; lane++)
    begin : g_lane
      assign wr_new[8*lane +: 8] = i_w_strb[lane] ? i_w_data[8*lane +: 8] : wr_old[8*lane +: 8];
    end
  endgenerate

  // write state machine
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      w_state <= AEP_W_IDLE;
      wr_cnt  <= 8'h00;
    end
    else
    begin
      unique case (w_state)
        AEP_W_IDLE: if (aw_take) w_state <= AEP_W_DATA;
        AEP_W_DATA: if (w_take && wr_end) w_state <= AEP_W_RESP;
        AEP_W_RESP: if (b_take) w_state <= AEP_W_IDLE;
        default:    w_state <= AEP_W_IDLE;
      endcase
      if (aw_take)
        wr_cnt <= 8'h00;
      else if (w_take)
        wr_cnt <= wr_cnt + 8'h01;
    end
  end

  // write request capture and address walk
  always_ff @(posedge i_ref_clk)
  begin
    if (aw_take)
    begin
      wr_addr   <= i_aw.addr;
      wr_len    <= aw_len;
      wr_size   <= i_aw.size;
      wr_burst  <= i_aw.burst;
      wr_region <= i_aw.region;
      o_b_id    <= i_aw.id;
    end
    else if (w_take)
      wr_addr <= aep_step(wr_addr, wr_size, wr_len, wr_burst);
  end

  // memory write port
  always_ff @(posedge i_ref_clk)
  begin
    if (w_take)
      mem[wr_idx] <= wr_new;
  end

  // read: next beat loads when the output slot is empty or draining
  wire             rd_issue = (r_state == AEP_R_DATA) && rd_pending && (!o_r_valid || i_r_ready);
  wire [IDX_W-1:0] rd_idx   = aep_index(rd_addr, rd_region);
  wire             rd_final = (rd_cnt == {1'b0, rd_len});

  // read state machine and output slot
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      r_state    <= AEP_R_IDLE;
      o_r_valid  <= 1'b0;
      o_r_last   <= 1'b0;
      rd_pending <= 1'b0;
      rd_cnt     <= 9'h000;
    end
    else
    begin
      if (ar_take)
      begin
        r_state    <= AEP_R_DATA;
        rd_pending <= 1'b1;
        rd_cnt     <= 9'h000;
      end
      if (rd_issue)
      begin
        o_r_valid <= 1'b1;
        o_r_last  <= rd_final;
        rd_cnt    <= rd_cnt + 9'h001;
        if (rd_final)
          rd_pending <= 1'b0;
      end
      else if (r_take)
      begin
        o_r_valid <= 1'b0;
        o_r_last  <= 1'b0;
        if (o_r_last)
          r_state <= AEP_R_IDLE;
      end
    end
  end

  // read request capture, data fetch and address walk
  always_ff @(posedge i_ref_clk)
  begin
    if (ar_take)
    begin
      rd_addr   <= i_ar.addr;
      rd_len    <= ar_len;
      rd_size   <= i_ar.size;
      rd_burst  <= i_ar.burst;
      rd_region <= i_ar.region;
      o_r_id    <= i_ar.id;
    end
    else if (rd_issue)
    begin
      o_r_data <= mem[rd_idx];
      rd_addr  <= aep_step(rd_addr, rd_size, rd_len, rd_burst);
    end
  end

  // control port decode
  wire sel_ctrl = (i_reg_addr == `AEP_CTRL_OFS);
  wire sel_stat = (i_reg_addr == `AEP_STAT_OFS);
  wire sel_wcnt = (i_reg_addr == `AEP_WCNT_OFS);
  wire sel_rcnt = (i_reg_addr == `AEP_RCNT_OFS);

  // status word shows both sides busy
  wire [31:0] stat_word = {30'h0, (r_state != AEP_R_IDLE), (w_state != AEP_W_IDLE)};

  // read mux; unmapped offsets read zero
  wire [31:0] next_rdata = sel_ctrl ? {31'h0, ctrl_en} :
                           sel_stat ? stat_word :
                           sel_wcnt ? {16'h0, wr_bursts} :
                           sel_rcnt ? {16'h0, rd_bursts} : 32'h0;

  // control register, burst counters, read data
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      ctrl_en     <= 1'(`AEP_CTRL_RST);
      wr_bursts   <= `AEP_CNT_RST;
      rd_bursts   <= `AEP_CNT_RST;
      o_reg_rdata <= 32'h0;
    end
    else
    begin
      if (i_reg_wr && sel_ctrl)
        ctrl_en <= i_reg_wdata[`AEP_CTRL_EN_BIT];
      if (b_take)
        wr_bursts <= wr_bursts + 16'h0001;
      if (r_take && o_r_last)
        rd_bursts <= rd_bursts + 16'h0001;
      o_reg_rdata <= i_reg_rd ? next_rdata : 32'h0;
    end
  end

  // checks kept next to the logic they guard
  width_legal_a: assert property (@(posedge i_ref_clk) WIDTH_OK)
    else $error("endpoint data width not a legal full width");

  lite_width_a: assert property (@(posedge i_ref_clk) LITE_OK)
    else $error("lite endpoint data width is not 32");

  valid_reset_a: assert property (@(posedge i_ref_clk) i_srst |=> !o_r_valid && !o_b_valid)
    else $error("valid output still high after reset");

  rbeat_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    o_r_valid && !i_r_ready |=> o_r_valid && $stable(o_r_data) && $stable(o_r_last))
    else $error("read beat changed while stalled");

  bresp_after_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    w_take && wr_end |=> o_b_valid)
    else $error("write response missing after last beat");

  okay_resp_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (o_b_valid |-> o_b_resp == `AEP_RESP_OKAY) and (o_r_valid |-> o_r_resp == `AEP_RESP_OKAY))
    else $error("response other than okay");

  rlast_count_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    o_r_valid && o_r_last |-> rd_cnt == {1'b0, rd_len} + 9'h001)
    else $error("read burst length does not match request");

  mode_removed_a: assert property (@(posedge i_ref_clk)
    (!HAS_WR |-> !o_aw_ready && !o_w_ready && !o_b_valid) and (!HAS_RD |-> !o_ar_ready && !o_r_valid))
    else $error("removed direction shows activity");

  wrap_window_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    w_take && wr_burst == `AEP_BURST_WRAP && !LITE
    |=> (wr_addr & ~((({24'h0, wr_len} + 32'h1) << wr_size) - 32'h1))
        == ($past(wr_addr) & ~((({24'h0, wr_len} + 32'h1) << wr_size) - 32'h1)))
    else $error("wrap burst left its window");

  busy_stall_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    !ctrl_en |-> !o_aw_ready && !o_ar_ready && !o_w_ready)
    else $error("endpoint accepted traffic while disabled");

  bvalid_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    o_b_valid && !i_b_ready |=> o_b_valid && $stable(o_b_id))
    else $error("write response changed while stalled");

  reset_ready_a: assert property (@(posedge i_ref_clk)
    i_srst |-> !o_aw_ready && !o_w_ready && !o_ar_ready)
    else $error("ready high during reset");

  wlen_end_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    w_take && (wr_cnt == wr_len) |=> o_b_valid)
    else $error("write burst ran past its length");

endmodule : aep_endpoint

// *** core/aep_pkg.sv ***
// types of the memory-mapped endpoint: address channel carrier and state encodings
// assumes the constants header sits beside it
package aep_pkg;

  // one address-channel request, write or read
  typedef struct packed {
    logic [31:0] addr;
    logic [3:0]  id;
    logic [7:0]  len;
    logic [2:0]  size;
    logic [1:0]  burst;
    logic        lock;
    logic [3:0]  cache;
    logic [2:0]  prot;
    logic [3:0]  qos;
    logic [3:0]  region;
    logic        user;
  } aep_addr_s;

  // write side progress
  typedef enum logic [1:0] {
    AEP_W_IDLE,
    AEP_W_DATA,
    AEP_W_RESP
  } aep_wst_e;

  // read side progress
  typedef enum logic {
    AEP_R_IDLE,
    AEP_R_DATA
  } aep_rst_e;

endpackage : aep_pkg

// *** core/aep_regs.svh ***
// constants of the memory-mapped endpoint: register offsets, fields, reset values, codes and timing
// assumes inclusion by bare name from the endpoint module, the bench and the master model
// Notes on behaviour
// - every channel has full valid/ready flow control; a beat moves only when both high.
// - incrementing bursts of 1 to 256 beats and wrapping bursts of 1 to 16 are accepted.
// - full data width is one of 32, 64, 128, 256, 512, 1024, fixed at build.
// - in lite mode the data path is exactly 32 bits wide.
// - narrow bursts work, stepping the address by the beat size; masters should avoid them.
// - interface builds as read-write, read-only or write-only; unused channels drop away.
// - no locked sequences; the lock bit gives no atomic guarantee and is ignored.
// - exclusive requests run as normal accesses and answer plain okay.
// - quality-of-service bits are ignored; behaviour never depends on them.
// - the slave may pick its address range from the region bits instead of decoding.
// - a master end never produces region bits; the interconnect does that. The bench's master model drives them from its rg input.
// - user sideband bits on every channel are ignored.
// - every valid output falls within eight clocks of reset.
// - no low-power request, acknowledge or activity ports exist.
`ifndef AEP_REGS_SVH
`define AEP_REGS_SVH

// register offsets, byte addresses
`define AEP_CTRL_OFS     8'h00
`define AEP_STAT_OFS     8'h04
`define AEP_WCNT_OFS     8'h08
`define AEP_RCNT_OFS     8'h0C

// field positions
`define AEP_CTRL_EN_BIT  0
`define AEP_STAT_WB_BIT  0
`define AEP_STAT_RB_BIT  1

// reset values
`define AEP_CTRL_RST     32'h0000_0001
`define AEP_CNT_RST      16'h0000

// protocol codes
`define AEP_RESP_OKAY    2'h0
`define AEP_BURST_FIXED  2'h0
`define AEP_BURST_INCR   2'h1
`define AEP_BURST_WRAP   2'h2

// access modes
`define AEP_MODE_RW      2'h0
`define AEP_MODE_RO      2'h1
`define AEP_MODE_WO      2'h2

// timing, in clock cycles
`define AEP_VALID_DROP_CYC 8
`define AEP_RESET_MIN_CYC  16

`endif

// *** testbench/aep_endpoint_test.sv ***
// self-checking bench of the endpoint: bursts through the master model, control port by tasks
// assumes the endpoint with default parameters and the master model beside it
`timescale 1ns/1ps
`include "aep_regs.svh"

module aep_endpoint_test
  import aep_pkg::*;
;
  // clock, reset and wires
  logic        clk = 1'b0;
  logic        srst;
  aep_addr_s   aw, ar;
  logic        aw_valid, aw_ready, w_last, w_user, w_valid, w_ready, b_user, b_valid, b_ready;
  logic        ar_valid, ar_ready, r_last, r_user, r_valid, r_ready, rg_wr, rg_rd;
  logic [31:0] w_data, r_data, rg_wdata, rg_rdata;
  logic [3:0]  w_strb, b_id, r_id;
  logic [1:0]  b_resp, r_resp;
  logic [7:0]  rg_addr;
  logic [31:0] mem [256];
  int          n_mismatch, n_checks, nw, nr, k;

  always #50 clk = ~clk;

  aep_endpoint uut (.i_ref_clk(clk), .i_srst(srst), .i_aw(aw), .i_aw_valid(aw_valid), .o_aw_ready(aw_ready),
    .i_w_data(w_data), .i_w_strb(w_strb), .i_w_last(w_last), .i_w_user(w_user), .i_w_valid(w_valid),
    .o_w_ready(w_ready), .o_b_id(b_id), .o_b_resp(b_resp), .o_b_user(b_user), .o_b_valid(b_valid),
    .i_b_ready(b_ready), .i_ar(ar), .i_ar_valid(ar_valid), .o_ar_ready(ar_ready), .o_r_id(r_id),
    .o_r_data(r_data), .o_r_resp(r_resp), .o_r_last(r_last), .o_r_user(r_user), .o_r_valid(r_valid),
    .i_r_ready(r_ready), .i_reg_addr(rg_addr), .i_reg_wdata(rg_wdata), .i_reg_wr(rg_wr),
    .i_reg_rd(rg_rd), .o_reg_rdata(rg_rdata));

  aep_master_model m (.i_ref_clk(clk), .o_aw(aw), .o_aw_valid(aw_valid), .i_aw_ready(aw_ready),
    .o_w_data(w_data), .o_w_strb(w_strb), .o_w_last(w_last), .o_w_user(w_user), .o_w_valid(w_valid),
    .i_w_ready(w_ready), .i_b_id(b_id), .i_b_resp(b_resp), .i_b_valid(b_valid), .o_b_ready(b_ready),
    .o_ar(ar), .o_ar_valid(ar_valid), .i_ar_ready(ar_ready), .i_r_id(r_id), .i_r_data(r_data),
    .i_r_resp(r_resp), .i_r_last(r_last), .i_r_valid(r_valid), .o_r_ready(r_ready));

  // one comparison, counted
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // control port accesses
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    rg_addr <= a;
    rg_wdata <= d;
    rg_wr <= 1'b1;
    @(posedge clk);
    rg_wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clk);
    rg_addr <= a;
    rg_rd <= 1'b1;
    @(posedge clk);
    rg_rd <= 1'b0;
    #1 chk(what, exp, rg_rdata);
  endtask : reg_rd

  // word index of beat i; region bit picks the upper half
  function automatic int widx(input logic [31:0] a, input logic [7:0] len, input logic [1:0] b,
                              input logic [3:0] rg, input int i);
    logic [31:0] w;
    logic [31:0] ba;
    w = ({24'h0, len} + 32'h1) << 2;
    ba = (b == `AEP_BURST_WRAP) ? ((a & ~(w - 32'h1)) | ((a + i * 4) & (w - 32'h1))) : (a + i * 4);
    return {rg[0], ba[8:2]};
  endfunction : widx

  // burst write, shadow memory kept in step
  task automatic wr(input logic [31:0] a, input logic [7:0] len, input logic [1:0] b, input logic [3:0] rg,
                    input logic [3:0] qos, input logic lk, input logic [31:0] base, input int stall);
    int i;
    @(posedge clk);
    m.wr(m.req(a, len, b, rg, qos, lk), base, stall);
    for (i = 0; i <= len; i++) mem[widx(a, len, b, rg, i)] = base + i;
    nw++;
    chk("b_resp", `AEP_RESP_OKAY, m.got_resp);
    chk("b_id", a[5:2], m.got_id);
  endtask : wr

  // burst read against the shadow memory
  task automatic rd(input logic [31:0] a, input logic [7:0] len, input logic [1:0] b, input logic [3:0] rg,
                    input logic [3:0] qos, input int stall);
    int i;
    @(posedge clk);
    m.rd(m.req(a, len, b, rg, qos, 1'b0), stall);
    nr++;
    for (i = 0; i <= len; i++) chk("r_data", mem[widx(a, len, b, rg, i)], m.rbuf[i]);
    chk("r_last", {24'h0, len}, m.last_idx);
    chk("r_resp", `AEP_RESP_OKAY, m.got_resp);
    chk("r_id", a[5:2], m.got_id);
  endtask : rd

  // closing verdict
  task automatic results();
    if (n_mismatch == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results

  // watchdog
  initial
  begin
    #5_000_000;
    n_mismatch++;
    results();
  end

  // test sequence
  initial
  begin
    {srst, rg_addr, rg_wdata, rg_wr, rg_rd} = {1'b1, 42'h0};
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1 chk("b_valid", 0, b_valid);
    chk("r_valid", 0, r_valid);
    reg_rd(`AEP_CTRL_OFS, `AEP_CTRL_RST, "ctrl");
    reg_rd(`AEP_WCNT_OFS, 0, "wcnt");
    reg_wr(8'h10, 32'hFFFF_FFFF);
    reg_rd(8'h10, 0, "unmapped");
    wr(0, 0, `AEP_BURST_INCR, 0, 0, 0, 32'h100, 0);
    rd(0, 0, `AEP_BURST_INCR, 0, 0, 0);
    wr(0, 8'hFF, `AEP_BURST_INCR, 0, 0, 0, 32'hA000, 1);
    rd(0, 8'hFF, `AEP_BURST_INCR, 0, 4'hF, 2);
    for (k = 0; k < 4; k++)
    begin
      wr(32'h4C, 8'((2 << k) - 1), `AEP_BURST_WRAP, 0, 0, 0, 32'hB000 + (k << 8), k);
      rd(32'h4C, 8'((2 << k) - 1), `AEP_BURST_WRAP, 0, 0, k);
    end
    wr(8, 0, `AEP_BURST_INCR, 1, 0, 0, 32'hC0, 0);
    rd(8, 0, `AEP_BURST_INCR, 0, 0, 0);
    rd(8, 0, `AEP_BURST_INCR, 1, 0, 0);
    wr(32'h20, 3, `AEP_BURST_INCR, 0, 4'hA, 1, 32'hE0, 0);
    rd(32'h20, 3, `AEP_BURST_INCR, 0, 4'h5, 1);
    chk("b_user", 0, b_user);
    chk("r_user", 0, r_user);
    reg_rd(`AEP_WCNT_OFS, nw, "wcnt");
    reg_rd(`AEP_RCNT_OFS, nr, "rcnt");
    reg_wr(`AEP_CTRL_OFS, 0);
    #1 chk("aw_ready_off", 0, aw_ready);
    chk("ar_ready_off", 0, ar_ready);
    reg_wr(`AEP_CTRL_OFS, 1);
    #1 chk("aw_ready_on", 1, aw_ready);
    // reset while a read beat stands unanswered
    @(posedge clk);
    m.ar_req(m.req(0, 3, `AEP_BURST_INCR, 0, 0, 0));
    reg_rd(`AEP_STAT_OFS, 32'h2, "stat");
    chk("r_valid_held", 1, r_valid);
    @(posedge clk);
    srst <= 1'b1;
    repeat (8) @(posedge clk);
    #1 chk("r_valid_reset", 0, r_valid);
    chk("b_valid_reset", 0, b_valid);
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    reg_rd(`AEP_RCNT_OFS, 0, "rcnt_reset");
    wr(32'h10, 1, `AEP_BURST_INCR, 0, 0, 0, 32'hF0, 0);
    rd(32'h10, 1, `AEP_BURST_INCR, 0, 0, 0);
    results();
  end

endmodule : aep_endpoint_test

// *** testbench/aep_master_model.sv ***
// master-side model of the endpoint's far end: issues write and read bursts on request
// assumes the bench calls its tasks right after a rising edge of the shared clock
`timescale 1ns/1ps
`include "aep_regs.svh"

module aep_master_model
  import aep_pkg::*;
(
  // clock
  input  wire logic        i_ref_clk,
  // write address and data
  output aep_addr_s        o_aw,
  output logic             o_aw_valid,
  input  wire logic        i_aw_ready,
  output logic [31:0]      o_w_data,
  output logic [3:0]       o_w_strb,
  output logic             o_w_last,
  output logic             o_w_user,
  output logic             o_w_valid,
  input  wire logic        i_w_ready,
  // write response
  input  wire logic [3:0]  i_b_id,
  input  wire logic [1:0]  i_b_resp,
  input  wire logic        i_b_valid,
  output logic             o_b_ready,
  // read address and data
  output aep_addr_s        o_ar,
  output logic             o_ar_valid,
  input  wire logic        i_ar_ready,
  input  wire logic [3:0]  i_r_id,
  input  wire logic [31:0] i_r_data,
  input  wire logic [1:0]  i_r_resp,
  input  wire logic        i_r_last,
  input  wire logic        i_r_valid,
  output logic             o_r_ready
);
  // answers captured for the bench
  logic [31:0] rbuf [256];
  logic [3:0]  got_id;
  logic [1:0]  got_resp;
  int          last_idx;

  // idle levels at time zero
  initial
  begin
    {o_aw, o_aw_valid, o_w_data, o_w_strb, o_w_last, o_w_user, o_w_valid} = '0;
    {o_b_ready, o_ar, o_ar_valid, o_r_ready} = '0;
  end

  // builds one request; id follows the address
  function automatic aep_addr_s req(input logic [31:0] a, input logic [7:0] len, input logic [1:0] b,
                                    input logic [3:0] rg, input logic [3:0] qos, input logic lk);
    aep_addr_s r;
    r = '0;
    r.addr = a;
    r.id = a[5:2];
    r.len = len;
    r.size = 3'h2;
    r.burst = b;
    r.lock = lk;
    r.cache = 4'h3;
    r.prot = 3'h0;
    r.qos = qos;
    r.region = rg;
    r.user = qos[0];
    return r;
  endfunction : req

  // write burst: address, whole beats in order, then response
  task automatic wr(input aep_addr_s q, input logic [31:0] base, input int stall);
    int i;
    o_aw <= q;
    o_aw_valid <= 1'b1;
    do @(posedge i_ref_clk); while (i_aw_ready !== 1'b1);
    o_aw_valid <= 1'b0;
    o_aw <= ~q;
    for (i = 0; i <= q.len; i++)
    begin
      o_w_data <= base + i;
      o_w_strb <= 4'hF;
      o_w_last <= (i == q.len);
      o_w_user <= i[0];
      o_w_valid <= 1'b1;
      do @(posedge i_ref_clk); while (i_w_ready !== 1'b1);
      if (i == q.len || stall > 0)
      begin
        o_w_valid <= 1'b0;
        o_w_data  <= ~(base + i);
      end
      repeat (stall) @(posedge i_ref_clk);
    end
    o_b_ready <= 1'b1;
    do @(posedge i_ref_clk); while (i_b_valid !== 1'b1);
    got_id = i_b_id;
    got_resp = i_b_resp;
    o_b_ready <= 1'b0;
  endtask : wr

  // read address phase only
  task automatic ar_req(input aep_addr_s q);
    o_ar <= q;
    o_ar_valid <= 1'b1;
    do @(posedge i_ref_clk); while (i_ar_ready !== 1'b1);
    o_ar_valid <= 1'b0;
    o_ar <= ~q;
  endtask : ar_req

  // read burst, stalling each beat when asked
  task automatic rd(input aep_addr_s q, input int stall);
    int i;
    ar_req(q);
    last_idx = -1;
    got_resp = '0;
    for (i = 0; i <= q.len; i++)
    begin
      repeat (stall) @(posedge i_ref_clk);
      o_r_ready <= 1'b1;
      do @(posedge i_ref_clk); while (i_r_valid !== 1'b1);
      rbuf[i] = i_r_data;
      got_id = i_r_id;
      got_resp = got_resp | i_r_resp;
      if (i_r_last === 1'b1 && last_idx < 0) last_idx = i;
      if (i == q.len || stall > 0) o_r_ready <= 1'b0;
    end
  endtask : rd

endmodule : aep_master_model
